//--- pkg/overlay_pkg.sv
`default_nettype none
package overlay_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] BASE_OFS = 8'h04;
  localparam logic [7:0] POS_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int POS_X_LSB = 0;
  localparam int POS_Y_LSB = 16;
  localparam int STATUS_Y_LSB = 16;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int COORD_W = 12;
  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam logic [31:0] POS_RESET = 32'h0000_0000;
  // Pixel, cursor, output buffer and fetch state layout
  localparam int BYPASS_SEL_BIT = 31;
  localparam int CUR_MODE_BIT = 15;
  localparam logic [11:0] CURSOR_DIM = 12'h020;
  localparam int WORDS_PER_ROW = 16;
  localparam logic [3:0] LAST_WORD = 4'hf;
  localparam int FIFO_DEPTH = 2;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  typedef enum {FETCH_IDLE, FETCH_BUSY} fetch_state_e;
endpackage : overlay_pkg
`default_nettype wire

//--- logic/direct_color_cursor_overlay.sv
// Function
// - Pixel bit 31 clear: low three bytes are LUT gamma indices, rest ignored.
// - Bit 31 set: 10-bit bypass colour, bytes give bits 9:2, 29:24 low.
// - Wider buses repeat the 32-bit word, lowest word first; here frame_pixel_bus is 32 bits only.
// - Hardware cursor is 32 by 32 pixels, 15-bit colour plus mode bit.
// - Cursor pattern fetched from 2KByte bitmap at programmable framestore base.
// - Registers hold cursor enable, bitmap base and cursor X and Y.
// - Cursor pixel: bit 15 mode, 14:10 red, 9:5 green, 4:0 blue.
// - Each 5-bit cursor component is replicated into both halves of 10 bits.
// - Mode bit one: widened cursor colour replaces the display pixel.
// - Mode bit zero: widened cursor colour XORed into display pixel.
// - Cursor pixel of zero leaves the display pixel untouched.
// - Cursor is mixed after video overlay, so it sits on top.
// - Bypass with fixed low bits serves as 8:8:8 without gamma.
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module direct_color_cursor_overlay (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic frame_start,
  input wire logic line_start,
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic [31:0] frame_pixel_bus,
  input wire logic video_active,
  input wire logic [29:0] video_rgb,
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic out_valid,
  input wire logic out_ready,
  output logic out_use_lut,
  output logic [29:0] out_rgb
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Register file
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] base_reg, base_next;
  logic [31:0] pos_reg, pos_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic addr_phase, cursor_en;
  logic [11:0] cur_x, cur_y;
  // Raster and fetch state
  logic [11:0] x_reg, x_next, y_reg, y_next, row_off, x_off, y_off;
  overlay_pkg::fetch_state_e state_reg, state_next;
  logic [3:0] word_reg, word_next;
  logic [4:0] row_reg, row_next;
  logic [31:0] addr_reg, addr_next, d;
  logic line_ok_reg, line_ok_next, new_line;
  logic [31:0] lb_reg [overlay_pkg::WORDS_PER_ROW];
  // Mixing
  logic dec_lut, base_lut, hit, mix_lut, push, pop;
  logic [29:0] dec_rgb, base_rgb, wide, mix_rgb;
  logic [15:0] cur_pix;
  // Output buffer
  logic [30:0] fifo_reg [overlay_pkg::FIFO_DEPTH];
  logic wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [1:0] count_reg, count_next;

  assign addr_phase = hsel & hready & htrans[1];
  assign cursor_en = ctrl_reg[overlay_pkg::CTRL_EN_BIT];
  assign cur_x = pos_reg[overlay_pkg::POS_X_LSB +: overlay_pkg::COORD_W];
  assign cur_y = pos_reg[overlay_pkg::POS_Y_LSB +: overlay_pkg::COORD_W];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  always_comb begin
    wr_pend_next = addr_phase & hwrite;
    wr_addr_next = addr_phase ? haddr[7:0] : wr_addr_reg;
    ctrl_next = ctrl_reg;
    base_next = base_reg;
    pos_next = pos_reg;
    hrdata_next = hrdata_reg;
    if (wr_pend_reg) begin
      case (wr_addr_reg)
        overlay_pkg::CTRL_OFS: ctrl_next = hwdata;
        overlay_pkg::BASE_OFS: base_next = hwdata;
        overlay_pkg::POS_OFS: pos_next = hwdata;
        default: ctrl_next = ctrl_reg;
      endcase
    end
    if (addr_phase & ~hwrite) begin
      case (haddr[7:0])
        overlay_pkg::CTRL_OFS: hrdata_next = ctrl_reg;
        overlay_pkg::BASE_OFS: hrdata_next = base_reg;
        overlay_pkg::POS_OFS: hrdata_next = pos_reg;
        overlay_pkg::STATUS_OFS: hrdata_next = {4'h0, y_reg, 15'h0,
            state_reg == overlay_pkg::FETCH_BUSY};
        default: hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      ctrl_reg <= overlay_pkg::CTRL_RESET;
      base_reg <= overlay_pkg::BASE_RESET;
      pos_reg <= overlay_pkg::POS_RESET;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      ctrl_reg <= ctrl_next;
      base_reg <= base_next;
      pos_reg <= pos_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // Raster position and per-line cursor row fetch
  assign new_line = frame_start | line_start;
  assign row_off = y_next - cur_y;
  assign mem_req = state_reg == overlay_pkg::FETCH_BUSY;
  assign mem_addr = addr_reg;

  always_comb begin
    x_next = x_reg;
    y_next = y_reg;
    state_next = state_reg;
    word_next = word_reg;
    row_next = row_reg;
    addr_next = addr_reg;
    line_ok_next = line_ok_reg;
    if (push) begin
      x_next = x_reg + 12'h001;
    end
    if (frame_start) begin
      y_next = 12'h000;
    end else if (line_start) begin
      y_next = y_reg + 12'h001;
    end
    case (state_reg)
      overlay_pkg::FETCH_IDLE: begin
        if (new_line) begin
          x_next = 12'h000;
          line_ok_next = 1'b0;
          if (cursor_en && row_off < overlay_pkg::CURSOR_DIM) begin
            state_next = overlay_pkg::FETCH_BUSY;
            word_next = 4'h0;
            row_next = row_off[4:0];
            addr_next = base_reg + {21'h0, row_off[4:0], 6'h00};
          end
        end
      end
      overlay_pkg::FETCH_BUSY: begin
        if (mem_ack) begin
          if (word_reg == overlay_pkg::LAST_WORD) begin
            state_next = overlay_pkg::FETCH_IDLE;
            line_ok_next = 1'b1;
          end else begin
            word_next = word_reg + 4'h1;
            addr_next = base_reg +
                {21'h0, row_reg, word_reg + 4'h1, 2'b00};
          end
        end
      end
      default: state_next = overlay_pkg::FETCH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      x_reg <= 12'h000;
      y_reg <= 12'h000;
      state_reg <= overlay_pkg::FETCH_IDLE;
      word_reg <= 4'h0;
      row_reg <= 5'h00;
      addr_reg <= 32'h0000_0000;
      line_ok_reg <= 1'b0;
    end else begin
      x_reg <= x_next;
      y_reg <= y_next;
      state_reg <= state_next;
      word_reg <= word_next;
      row_reg <= row_next;
      addr_reg <= addr_next;
      line_ok_reg <= line_ok_next;
    end
  end

  // One cursor row: 16 words of two pixels, even pixel in low half
  generate
    for (genvar i = 0; i < overlay_pkg::WORDS_PER_ROW; i++) begin : g_line
      logic [31:0] lb_next;
      always_comb begin
        lb_next = lb_reg[i];
        if (mem_req && mem_ack && word_reg == 4'(i)) begin
          lb_next = mem_rdata;
        end
      end
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          lb_reg[i] <= 32'h0000_0000;
        end else begin
          lb_reg[i] <= lb_next;
        end
      end
    end
  endgenerate

  // Pixel decode, video overlay, then cursor mix
  assign d = frame_pixel_bus;
  assign dec_lut = ~d[overlay_pkg::BYPASS_SEL_BIT];
  assign dec_rgb = dec_lut ?
      {d[23:16], 2'b00, d[15:8], 2'b00, d[7:0], 2'b00} :
      {d[23:16], d[29:28], d[15:8], d[27:26], d[7:0], d[25:24]};
  assign base_lut = video_active ? 1'b0 : dec_lut;
  assign base_rgb = video_active ? video_rgb : dec_rgb;
  assign x_off = x_reg - cur_x;
  assign y_off = y_reg - cur_y;
  assign hit = cursor_en && line_ok_reg &&
      x_off < overlay_pkg::CURSOR_DIM && y_off < overlay_pkg::CURSOR_DIM;
  assign cur_pix = x_off[0] ? lb_reg[x_off[4:1]][31:16] :
      lb_reg[x_off[4:1]][15:0];
  assign wide = {cur_pix[14:10], cur_pix[14:10], cur_pix[9:5], cur_pix[9:5],
      cur_pix[4:0], cur_pix[4:0]};

  always_comb begin
    mix_lut = base_lut;
    mix_rgb = base_rgb;
    if (!hit || cur_pix == 16'h0000) begin
      mix_rgb = base_rgb;
    end else if (cur_pix[overlay_pkg::CUR_MODE_BIT]) begin
      mix_lut = 1'b0;
      mix_rgb = wide;
    end else begin
      mix_rgb = base_rgb ^ wide;
    end
  end

  // Two-entry output buffer
  assign pix_ready = count_reg != overlay_pkg::FIFO_FULL && !new_line &&
      state_reg == overlay_pkg::FETCH_IDLE;
  assign push = pix_valid & pix_ready;
  assign out_valid = count_reg != 2'h0;
  assign pop = out_valid & out_ready;
  assign out_use_lut = fifo_reg[rd_ptr_reg][30];
  assign out_rgb = fifo_reg[rd_ptr_reg][29:0];

  always_comb begin
    wr_ptr_next = push ? ~wr_ptr_reg : wr_ptr_reg;
    rd_ptr_next = pop ? ~rd_ptr_reg : rd_ptr_reg;
    count_next = count_reg + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  generate
    for (genvar e = 0; e < overlay_pkg::FIFO_DEPTH; e++) begin : g_fifo
      logic [30:0] fifo_next;
      always_comb begin
        fifo_next = fifo_reg[e];
        if (push && wr_ptr_reg == 1'(e)) begin
          fifo_next = {mix_lut, mix_rgb};
        end
      end
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          fifo_reg[e] <= 31'h0;
        end else begin
          fifo_reg[e] <= fifo_next;
        end
      end
    end
  endgenerate

  // Checks
  a_lut_path: assert property (push && !video_active && !d[31] |->
      mix_lut == !hit && mix_rgb[29:22] == (d[23:16] ^ (hit ? wide[29:22] :
      8'h00)) || hit) else $error("LUT path decode wrong");
  a_bypass_bits: assert property (push && !video_active && d[31] && !hit
      |-> !mix_lut && mix_rgb == {d[23:16], d[29:28], d[15:8], d[27:26],
      d[7:0], d[25:24]}) else $error("bypass decode wrong");
  a_replace_mode: assert property (push && hit && cur_pix[15] |->
      !mix_lut && mix_rgb[29:25] == cur_pix[14:10] &&
      mix_rgb[24:20] == cur_pix[14:10] && mix_rgb[4:0] == cur_pix[4:0])
      else $error("replace colour wrong");
  a_xor_mode: assert property (push && hit && !cur_pix[15] |->
      mix_rgb == (base_rgb ^ {cur_pix[14:10], cur_pix[14:10], cur_pix[9:5],
      cur_pix[9:5], cur_pix[4:0], cur_pix[4:0]})) else $error("XOR wrong");
  a_transparent: assert property (push && hit && cur_pix == 16'h0000 |->
      mix_rgb == base_rgb && mix_lut == base_lut) else $error("not clear");
  a_pass_outside: assert property (push && !cursor_en |->
      mix_rgb == base_rgb) else $error("pixel altered with cursor off");
  a_video_under: assert property (push && video_active && !hit |->
      mix_rgb == video_rgb && !mix_lut) else $error("video not passed");

  sequence s_fetch_start;
    state_reg == overlay_pkg::FETCH_IDLE && new_line && cursor_en &&
        row_off < overlay_pkg::CURSOR_DIM;
  endsequence
  sequence s_first_word;
    mem_req && mem_addr == $past(base_reg) + {21'h0, $past(row_off[4:0]),
        6'h00};
  endsequence
  a_fetch_base: assert property (s_fetch_start |=> s_first_word)
      else $error("cursor row address wrong");
  sequence s_last_ack;
    mem_req && mem_ack && word_reg == overlay_pkg::LAST_WORD;
  endsequence
  a_fetch_done: assert property (s_last_ack |=> !mem_req && line_ok_reg
      && lb_reg[15] == $past(mem_rdata)) else $error("fetch end wrong");
  a_enable_write: assert property (wr_pend_reg && wr_addr_reg ==
      overlay_pkg::CTRL_OFS |=> cursor_en == $past(hwdata[0]))
      else $error("enable not written");
endmodule : direct_color_cursor_overlay
`default_nettype wire

//--- verification/cursor_store_model.sv
`timescale 1ns/100ps
`default_nettype none
module cursor_store_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [1:0] lag,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:511];
  logic [1:0] wait_cnt;
  // Data toggles outside an ack so stale words never look valid
  always_ff @(posedge ref_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!reset_n) begin
      wait_cnt <= 2'h0;
      mem_rdata <= 32'h5a5a_a5a5;
    end else if (mem_req && !mem_ack) begin
      if (wait_cnt >= lag) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem[mem_addr[10:2]];
        wait_cnt <= 2'h0;
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule : cursor_store_model
`default_nettype wire

//--- verification/tb_direct_color_cursor_overlay.sv
`timescale 1ns/100ps
`default_nettype none
module tb_direct_color_cursor_overlay;
  logic ref_clk, reset_n, hsel, hwrite, hreadyout, hresp, frame_start;
  logic line_start, pix_valid, pix_ready, video_active, mem_req, mem_ack;
  logic out_valid, out_ready, out_use_lut, en, stall;
  logic [31:0] haddr, hwdata, hrdata, pix, mem_addr, mem_rdata, seed, rd;
  logic [31:0] seed_b;
  logic [1:0] htrans, lag;
  logic [2:0] hsize;
  logic [29:0] video_rgb, out_rgb;
  logic [31:0] cmem [0:511];
  logic [30:0] expq[$];
  int n_mismatch, total_checks, x, line, cx, cy;

  direct_color_cursor_overlay uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .frame_start(frame_start), .line_start(line_start),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .frame_pixel_bus(pix),
    .video_active(video_active), .video_rgb(video_rgb), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .out_valid(out_valid), .out_ready(out_ready),
    .out_use_lut(out_use_lut), .out_rgb(out_rgb));
  cursor_store_model fb (.ref_clk(ref_clk), .reset_n(reset_n), .lag(lag),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [29:0] widen(input logic [14:0] c);
    return {c[14:10], c[14:10], c[9:5], c[9:5], c[4:0], c[4:0]};
  endfunction : widen

  function automatic logic [30:0] model_pix(input logic [31:0] p,
      input logic va, input logic [29:0] vr);
    logic [30:0] r;
    logic [31:0] w;
    logic [15:0] cp;
    int c;
    c = x - cx;
    if (p[31]) r = {1'b0, p[23:16], p[29:28], p[15:8], p[27:26], p[7:0],
      p[25:24]};
    else r = {1'b1, p[23:16], 2'b00, p[15:8], 2'b00, p[7:0], 2'b00};
    if (va) r = {1'b0, vr};
    if (en && c >= 0 && c < 32 && line >= cy && line < cy + 32) begin
      w = cmem[16 * (line - cy) + c / 2];
      cp = c[0] ? w[31:16] : w[15:0];
      if (cp === 16'h0) r = r;
      else if (cp[15]) r = {1'b0, widen(cp[14:0])};
      else r = r ^ {1'b0, widen(cp[14:0])};
    end
    return r;
  endfunction : model_pix

  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task chk_pix(input logic [30:0] got, input logic [30:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t pixel got %h exp %h", $time, got, exp);
    end
  endtask : chk_pix

  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rdv);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : ahb

  task run_line(input logic first, input int n);
    frame_start <= first;
    line_start <= !first;
    @(posedge ref_clk);
    frame_start <= 1'b0;
    line_start <= 1'b0;
    line = first ? 0 : line + 1;
    x = 0;
    for (int i = 0; i < n; i++) begin
      pix_valid <= 1'b1;
      pix <= seed;
      video_active <= seed[9:8] == 2'b11;
      video_rgb <= ~seed[29:0];
      do @(posedge ref_clk); while (pix_ready !== 1'b1);
      expq.push_back(model_pix(pix, video_active, video_rgb));
      x++;
      seed = xs(seed);
    end
    pix_valid <= 1'b0;
  endtask : run_line

  task conclude();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    out_ready <= !stall && seed_b[1:0] != 2'b00;
    seed_b = xs(seed_b);
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      chk_pix({out_use_lut, out_rgb}, expq.pop_front());
    end
  end

  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end

  initial begin
    {hsel, hwrite, frame_start, line_start, pix_valid, video_active} = '0;
    {haddr, hwdata, pix, htrans, hsize, video_rgb} = '0;
    {reset_n, out_ready, stall, en, lag} = '0;
    n_mismatch = 0;
    total_checks = 0;
    seed = 32'h60f7993e;
    seed_b = ~seed;
    cx = 5;
    cy = 1;
    for (int i = 0; i < 512; i++) begin
      cmem[i] = seed;
      seed = xs(seed);
    end
    cmem[0] = 32'h7fff_0000;
    cmem[1] = 32'h8000_ffff;
    for (int i = 0; i < 512; i++) fb.mem[i] = cmem[i];
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    ahb(1'b0, overlay_pkg::CTRL_OFS, 32'h0, rd);
    chk_reg(rd, overlay_pkg::CTRL_RESET);
    ahb(1'b0, overlay_pkg::BASE_OFS, 32'h0, rd);
    chk_reg(rd, overlay_pkg::BASE_RESET);
    ahb(1'b0, overlay_pkg::POS_OFS, 32'h0, rd);
    chk_reg(rd, overlay_pkg::POS_RESET);
    ahb(1'b1, overlay_pkg::BASE_OFS, 32'h0000_1000, rd);
    ahb(1'b1, overlay_pkg::POS_OFS, 32'h0001_0005, rd);
    ahb(1'b1, overlay_pkg::CTRL_OFS, 32'h1, rd);
    en = 1'b1;
    ahb(1'b1, 8'h10, 32'hffff_ffff, rd);
    ahb(1'b0, 8'h10, 32'h0, rd);
    chk_reg(rd, 32'h0);
    ahb(1'b0, overlay_pkg::BASE_OFS, 32'h0, rd);
    chk_reg(rd, 32'h0000_1000);
    ahb(1'b0, overlay_pkg::POS_OFS, 32'h0, rd);
    chk_reg(rd, 32'h0001_0005);
    run_line(1'b1, 40);
    run_line(1'b0, 40);
    do @(posedge ref_clk); while (expq.size() != 0);
    lag <= 2'h3;
    stall <= 1'b1;
    run_line(1'b0, 2);
    @(posedge ref_clk);
    chk_reg({31'h0, pix_ready}, 32'h0);
    stall <= 1'b0;
    ahb(1'b1, overlay_pkg::CTRL_OFS, 32'h0, rd);
    en = 1'b0;
    run_line(1'b0, 40);
    ahb(1'b0, overlay_pkg::STATUS_OFS, 32'h0, rd);
    chk_reg({20'h0, rd[27:16]}, 32'h3);
    do @(posedge ref_clk); while (expq.size() != 0);
    @(posedge ref_clk);
    chk_reg({31'h0, out_valid}, 32'h0);
    chk_reg({31'h0, hresp}, 32'h0);
    conclude();
  end
endmodule : tb_direct_color_cursor_overlay
`default_nettype wire
